/* File: core/plpt_phy_end.sv */
// Phy end of the phy-link packet port: grant, prefix, receive framing, power field
module plpt_phy_end (
  input wire logic clock,
  input wire logic rst,
  plpt_if.phy bus,
  input wire logic arb_won,
  input wire logic node_is_root,
  input wire logic iso_mode,
  input wire logic cable_rx_active,
  input wire logic cable_rx_valid,
  input wire logic [3:0] cable_rx_data,
  input wire logic cable_rx_speed200,
  input wire logic [2:0] power_class_pins,
  output logic cable_tx_valid,
  output logic [3:0] cable_tx_data,
  output logic cable_tx_prefix,
  output logic [2:0] pwr_field,
  output logic pwr_bus_powered,
  output logic pwr_self_powered,
  output logic [5:0] pwr_watts
);
  typedef enum logic [3:0] {
    P_IDLE = 4'h0,
    P_EXT = 4'h1,
    P_GRANT = 4'h2,
    P_GIDLE = 4'h3,
    P_LINK = 4'h4,
    P_GAP = 4'h5,
    P_RX_PRE = 4'h6,
    P_RX_SPD = 4'h7,
    P_RX_DATA = 4'h8,
    P_END = 4'h9
  } plpt_pst_t;

  plpt_pst_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic sent_q, sent_d;
  logic speed_q, speed_d;
  logic oe_q, oe_d;
  logic [1:0] ctl_q, ctl_d;
  logic [3:0] dat_q, dat_d;
  logic txv_q, txv_d;
  logic [3:0] txd_q, txd_d;
  logic pfx_q, pfx_d;

  // ----------------------------------------------------------------
  // Interface state machine
  // ----------------------------------------------------------------
  // Next state and the cable-side strobes, decided from the current state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sent_d = sent_q;
    speed_d = speed_q;
    txv_d = 1'b0;
    txd_d = 4'h0;
    pfx_d = 1'b0;
    case (st_q)
      P_IDLE: begin
        // receive wins; a pending request waits
        if (cable_rx_active) begin
          st_d = P_RX_PRE;
          speed_d = cable_rx_speed200;
        end else if (bus.link_bus_request_pin) begin
          if (node_is_root && iso_mode) begin
            st_d = P_EXT;
            cnt_d = plpt_pkg::PREFIX_EXT_CYC - 8'h01;
          end else if (arb_won) begin
            st_d = P_GRANT;
          end
        end
      end
      P_EXT: begin
        pfx_d = 1'b1;
        if (cnt_q == 8'h00) begin
          st_d = P_GRANT;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      P_GRANT: begin
        st_d = P_GIDLE;
      end
      P_GIDLE: begin
        st_d = P_LINK;
        sent_d = 1'b0;
      end
      P_LINK: begin
        case (bus.ctl)
          plpt_pkg::LCTL_TRANSMIT: begin
            sent_d = 1'b1;
            txv_d = 1'b1;
            txd_d = bus.d;
          end
          plpt_pkg::LCTL_HOLD: begin
            // hold after a packet asks for another
            if (sent_q) begin
              st_d = P_GAP;
              cnt_d = plpt_pkg::HOLD_GAP_CYC - 8'h01;
            end else begin
              pfx_d = 1'b1;
            end
          end
          default: begin
            st_d = P_END;
          end
        endcase
      end
      P_GAP: begin
        pfx_d = 1'b1;
        if (cnt_q == 8'h00) begin
          st_d = P_GRANT;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      P_RX_PRE: begin
        st_d = P_RX_SPD;
      end
      P_RX_SPD: begin
        st_d = P_RX_DATA;
      end
      P_RX_DATA: begin
        if (!cable_rx_active) begin
          st_d = P_END;
        end
      end
      P_END: begin
        st_d = P_IDLE;
      end
      default: begin
        st_d = P_IDLE;
      end
    endcase
  end

  // Pin values follow the state being entered, so they leave a flop
  always_comb begin
    oe_d = 1'b0;
    ctl_d = plpt_pkg::CTL_IDLE;
    dat_d = 4'h0;
    case (st_d)
      P_GRANT: begin
        oe_d = 1'b1;
        ctl_d = plpt_pkg::CTL_TRANSMIT;
      end
      P_GIDLE, P_GAP, P_END: begin
        oe_d = 1'b1;
      end
      P_RX_PRE: begin
        oe_d = 1'b1;
        ctl_d = plpt_pkg::CTL_RECEIVE;
        dat_d = plpt_pkg::DATA_ONES;
      end
      P_RX_SPD: begin
        oe_d = 1'b1;
        ctl_d = plpt_pkg::CTL_RECEIVE;
        dat_d = speed_q ? plpt_pkg::SPEED_200 : plpt_pkg::SPEED_100;
      end
      P_RX_DATA: begin
        // packet words only after the speed code
        oe_d = 1'b1;
        ctl_d = plpt_pkg::CTL_RECEIVE;
        if (cable_rx_valid) begin
          dat_d = speed_q ? cable_rx_data : (cable_rx_data & plpt_pkg::MASK_100);
        end
      end
      default: begin
        oe_d = 1'b0;
      end
    endcase
  end

  // every line moves on the rising edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= P_IDLE;
      cnt_q <= 8'h00;
      sent_q <= 1'b0;
      speed_q <= 1'b0;
      oe_q <= 1'b0;
      ctl_q <= plpt_pkg::CTL_IDLE;
      dat_q <= 4'h0;
      txv_q <= 1'b0;
      txd_q <= 4'h0;
      pfx_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sent_q <= sent_d;
      speed_q <= speed_d;
      oe_q <= oe_d;
      ctl_q <= ctl_d;
      dat_q <= dat_d;
      txv_q <= txv_d;
      txd_q <= txd_d;
      pfx_q <= pfx_d;
    end
  end

  assign bus.phy_oe = oe_q;
  assign bus.phy_ctl = ctl_q;
  assign bus.phy_d = dat_q;
  assign cable_tx_valid = txv_q;
  assign cable_tx_data = txd_q;
  assign cable_tx_prefix = pfx_q;

  // ----------------------------------------------------------------
  // Power class pins
  // ----------------------------------------------------------------
  logic [2:0] pwr_m_q, pwr_s_q;
  logic [2:0] pf_q, pf_d;
  logic bp_q, bp_d, sp_q, sp_d;
  logic [5:0] pw_q, pw_d;

  // Field index 0 is bit 21, so it leaves the serializer first
  always_comb begin
    pf_d = pwr_s_q;
    bp_d = pwr_s_q[0];
    sp_d = !pwr_s_q[0] && (pwr_s_q[1] || pwr_s_q[2]);
    pw_d = plpt_pkg::PWR_WATTS[{pwr_s_q[0], pwr_s_q[1], pwr_s_q[2]}];
  end

  // Straps are static but still pass three flops; the first feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_m_q <= 3'h0;
      pwr_s_q <= 3'h0;
      pf_q <= 3'h0;
      bp_q <= 1'b0;
      sp_q <= 1'b0;
      pw_q <= 6'h00;
    end else begin
      pwr_m_q <= power_class_pins;
      pwr_s_q <= pwr_m_q;
      pf_q <= pf_d;
      bp_q <= bp_d;
      sp_q <= sp_d;
      pw_q <= pw_d;
    end
  end

  assign pwr_field = pf_q;
  assign pwr_bus_powered = bp_q;
  assign pwr_self_powered = sp_q;
  assign pwr_watts = pw_q;
endmodule

/* File: core/plpt_pkg.sv */
// Shared encodings and timing constants of the phy-link packet port
package plpt_pkg;
  // ----------------------------------------------------------------
  // Control line codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_TRANSMIT = 2'h3;
  localparam logic [1:0] LCTL_IDLE = 2'h0;
  localparam logic [1:0] LCTL_HOLD = 2'h1;
  localparam logic [1:0] LCTL_TRANSMIT = 2'h3;
  // ----------------------------------------------------------------
  // Data line codes
  // ----------------------------------------------------------------
  localparam logic [3:0] DATA_ONES = 4'hF;
  localparam logic [3:0] SPEED_100 = 4'h0;
  localparam logic [3:0] SPEED_200 = 4'h4;
  localparam logic [3:0] SPEED_MASK = 4'hC;
  localparam logic [3:0] MASK_100 = 4'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int HOLD_GAP_NS = 40;
  localparam int PREFIX_EXT_NS = 200;
  localparam logic [7:0] HOLD_GAP_CYC = 8'((HOLD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PREFIX_EXT_CYC = 8'((PREFIX_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // Power field: index is {bit21, bit22, bit23}, watts supplied or extra needed
  // ----------------------------------------------------------------
  localparam logic [5:0] PWR_WATTS [8] = '{6'h00, 6'h0F, 6'h1E, 6'h2D, 6'h00, 6'h02, 6'h05, 6'h09};
endpackage

/* File: core/plpt_if.sv */
// Control, data and request wires between the phy end and the link end
interface plpt_if (
  input wire logic clk
);
  logic phy_oe;
  logic [1:0] phy_ctl;
  logic [3:0] phy_d;
  logic link_oe;
  logic [1:0] link_ctl;
  logic [3:0] link_d;
  logic link_bus_request_pin;
  logic [1:0] ctl;
  logic [3:0] d;

  // Undriven lines read as idle and zero, as the bus holders leave them
  assign ctl = phy_oe ? phy_ctl : (link_oe ? link_ctl : 2'h0);
  assign d = phy_oe ? phy_d : (link_oe ? link_d : 4'h0);

  modport phy (input clk, input link_bus_request_pin, input ctl, input d,
               output phy_oe, output phy_ctl, output phy_d);
  modport link (input clk, input ctl, input d,
                output link_oe, output link_ctl, output link_d, output link_bus_request_pin);
endinterface

/* File: core/plpt_fifo.sv */
// Synchronous FIFO with registered full and empty flags
module plpt_fifo #(
  parameter int W = 5,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  // Pointer wrap relies on a power-of-two depth
  if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad_cfg
    $error("plpt_fifo: depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  // ----------------------------------------------------------------
  // Pointer and flag update
  // ----------------------------------------------------------------
  always_comb begin
    push = in_valid && !full_q;
    pop = out_ready && !empty_q;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    full_d = cnt_d == (AW + 1)'(D);
    empty_d = cnt_d == '0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  // Storage has no reset; words are only read once written
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  assign in_ready = !full_q;
  assign out_valid = !empty_q;
  assign out_data = mem_q[rp_q];
endmodule

/* File: core/plpt_link_end.sv */
// Link end of the phy-link packet port: request, transmit from FIFO, receive
module plpt_link_end (
  input wire logic clock,
  input wire logic rst,
  plpt_if.link bus,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [3:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_speed200,
  output logic rx_valid,
  output logic [3:0] rx_data,
  output logic rx_speed200,
  output logic rx_end,
  output logic req_lost
);
  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_REQ = 3'h1,
    L_GRANT = 3'h2,
    L_TX = 3'h3,
    L_HOLD = 3'h4,
    L_WAITG = 3'h5,
    L_END = 3'h6
  } plpt_lst_t;

  typedef enum logic [1:0] {
    R_NONE = 2'h0,
    R_PRE = 2'h1,
    R_DATA = 2'h2
  } plpt_rph_t;

  logic f_valid, f_pop, f_in_ready;
  logic [4:0] f_data;
  logic push_last;

  // Words wait here until a whole packet is queued; waiting for grant fills it
  plpt_fifo #(.W(5), .D(8)) plpt_fifo_inst (
    .clock(clock),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(f_in_ready),
    .in_data({tx_last, tx_data}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );
  assign tx_ready = f_in_ready;
  assign push_last = tx_valid && f_in_ready && tx_last;

  plpt_lst_t st_q, st_d;
  logic [3:0] pk_q, pk_d;
  logic idle_prev_q, idle_prev_d;
  logic speed_q, speed_d;
  logic last_q, last_d;
  logic lost_q, lost_d;
  logic oe_q, oe_d, req_pin_q, req_pin_d;
  logic [1:0] ctl_q, ctl_d;
  logic [3:0] dat_q, dat_d;

  // ----------------------------------------------------------------
  // Transmit state machine
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    speed_d = speed_q;
    last_d = last_q;
    lost_d = 1'b0;
    f_pop = 1'b0;
    idle_prev_d = bus.ctl == plpt_pkg::CTL_IDLE;
    case (st_q)
      L_IDLE: begin
        // request after a full idle clock
        if (pk_q != 4'h0 && idle_prev_q && bus.ctl == plpt_pkg::CTL_IDLE) begin
          st_d = L_REQ;
          // one speed for the whole ownership
          speed_d = tx_speed200;
        end
      end
      L_REQ: begin
        // receive code means the request was lost
        if (bus.ctl == plpt_pkg::CTL_RECEIVE) begin
          st_d = L_IDLE;
          lost_d = 1'b1;
        end else if (bus.ctl == plpt_pkg::CTL_TRANSMIT) begin
          st_d = L_GRANT;
        end
      end
      L_GRANT, L_WAITG: begin
        // take the bus once grant turns idle
        if (st_q == L_GRANT && bus.ctl == plpt_pkg::CTL_IDLE) begin
          st_d = L_TX;
          f_pop = 1'b1;
          last_d = f_data[4];
        end else if (st_q == L_WAITG && bus.ctl == plpt_pkg::CTL_TRANSMIT) begin
          st_d = L_GRANT;
        end
      end
      L_TX: begin
        // transmit stays up to the last word
        if (last_q) begin
          // hold when another whole packet is queued
          st_d = (pk_q != 4'h0) ? L_HOLD : L_END;
        end else if (f_valid) begin
          f_pop = 1'b1;
          last_d = f_data[4];
        end else begin
          st_d = L_END;
        end
      end
      L_HOLD: begin
        st_d = L_WAITG;
      end
      L_END: begin
        st_d = L_IDLE;
      end
      default: begin
        st_d = L_IDLE;
      end
    endcase
    pk_d = pk_q + 4'(push_last) - 4'(f_pop && f_data[4]);
  end

  // Pin values for the state being entered
  always_comb begin
    oe_d = 1'b0;
    ctl_d = plpt_pkg::LCTL_IDLE;
    dat_d = 4'h0;
    req_pin_d = st_d == L_REQ;
    case (st_d)
      L_TX: begin
        // four lines at 200, two at 100
        oe_d = 1'b1;
        ctl_d = plpt_pkg::LCTL_TRANSMIT;
        dat_d = speed_d ? f_data[3:0] : (f_data[3:0] & plpt_pkg::MASK_100);
      end
      L_HOLD: begin
        oe_d = 1'b1;
        ctl_d = plpt_pkg::LCTL_HOLD;
      end
      L_END: begin
        oe_d = 1'b1;
      end
      default: begin
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= L_IDLE;
      pk_q <= 4'h0;
      idle_prev_q <= 1'b0;
      speed_q <= 1'b0;
      last_q <= 1'b0;
      lost_q <= 1'b0;
      oe_q <= 1'b0;
      req_pin_q <= 1'b0;
      ctl_q <= plpt_pkg::LCTL_IDLE;
      dat_q <= 4'h0;
    end else begin
      st_q <= st_d;
      pk_q <= pk_d;
      idle_prev_q <= idle_prev_d;
      speed_q <= speed_d;
      last_q <= last_d;
      lost_q <= lost_d;
      oe_q <= oe_d;
      req_pin_q <= req_pin_d;
      ctl_q <= ctl_d;
      dat_q <= dat_d;
    end
  end

  assign bus.link_oe = oe_q;
  assign bus.link_ctl = ctl_q;
  assign bus.link_d = dat_q;
  assign bus.link_bus_request_pin = req_pin_q;
  assign req_lost = lost_q;

  // ----------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------
  plpt_rph_t rph_q, rph_d;
  logic rxv_q, rxv_d, rxs_q, rxs_d, rxe_q, rxe_d;
  logic [3:0] rxd_q, rxd_d;

  always_comb begin
    rph_d = rph_q;
    rxs_d = rxs_q;
    rxv_d = 1'b0;
    rxd_d = 4'h0;
    rxe_d = 1'b0;
    if (bus.ctl == plpt_pkg::CTL_RECEIVE) begin
      if (rph_q != R_DATA && bus.d == plpt_pkg::DATA_ONES) begin
        rph_d = R_PRE;
      end else if (rph_q == R_PRE) begin
        // speed word decoded, never passed on
        rph_d = R_DATA;
        rxs_d = (bus.d & plpt_pkg::SPEED_MASK) == plpt_pkg::SPEED_200;
      end else if (rph_q == R_DATA) begin
        rxv_d = 1'b1;
        rxd_d = rxs_q ? bus.d : (bus.d & plpt_pkg::MASK_100);
      end
    end else if (rph_q != R_NONE) begin
      rph_d = R_NONE;
      rxe_d = rph_q == R_DATA;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rph_q <= R_NONE;
      rxv_q <= 1'b0;
      rxs_q <= 1'b0;
      rxe_q <= 1'b0;
      rxd_q <= 4'h0;
    end else begin
      rph_q <= rph_d;
      rxv_q <= rxv_d;
      rxs_q <= rxs_d;
      rxe_q <= rxe_d;
      rxd_q <= rxd_d;
    end
  end

  assign rx_valid = rxv_q;
  assign rx_data = rxd_q;
  assign rx_speed200 = rxs_q;
  assign rx_end = rxe_q;
endmodule

/* File: dv/plpt_monitor.sv */
// Interface checker for the phy-link packet port
module plpt_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic phy_oe,
  input wire logic [1:0] phy_ctl,
  input wire logic [3:0] phy_d,
  input wire logic link_oe,
  input wire logic [1:0] link_ctl,
  input wire logic [3:0] link_d,
  input wire logic link_bus_request_pin,
  input wire logic [1:0] ctl,
  input wire logic [3:0] d
);
  logic live_d;
  logic live_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Masks history checks on the first edge after any reset
  always_comb begin
    live_d = 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_q <= 1'b0;
    end else begin
      live_q <= live_d;
    end
  end
  sequence rx_start;
    ctl == plpt_pkg::CTL_RECEIVE && $past(ctl) != plpt_pkg::CTL_RECEIVE;
  endsequence
  sequence rx_over;
    ctl == plpt_pkg::CTL_RECEIVE ##1 ctl != plpt_pkg::CTL_RECEIVE;
  endsequence
  sequence link_left(logic [1:0] code);
    live_q && $fell(link_oe) && $past(link_ctl) == code;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_grant_then_idle: assert property (phy_oe && phy_ctl == plpt_pkg::CTL_TRANSMIT |=>
    phy_oe && phy_ctl == plpt_pkg::CTL_IDLE) else $error("grant not followed by idle");
  a_rx_ones_first: assert property (live_q ##0 rx_start |-> d == plpt_pkg::DATA_ONES)
    else $error("receive did not open with all ones");
  a_rx_speed_code: assert property (live_q ##0 rx_start |=>
    d == plpt_pkg::SPEED_200 || d == plpt_pkg::SPEED_100) else $error("bad speed code");
  a_rx_end_idle: assert property (rx_over |-> phy_oe && ctl == plpt_pkg::CTL_IDLE)
    else $error("receive not closed by phy idle");
  a_single_driver: assert property (!(phy_oe && link_oe))
    else $error("both ends drive the lines");
  a_link_idle_once: assert property (link_oe && link_ctl == plpt_pkg::LCTL_IDLE |=>
    !link_oe) else $error("link idle not one cycle");
  a_phy_idle_after: assert property (link_left(plpt_pkg::LCTL_IDLE) |->
    phy_oe && phy_ctl == plpt_pkg::CTL_IDLE ##1 !phy_oe) else $error("phy idle missing");
  a_hold_regrant: assert property (link_left(plpt_pkg::LCTL_HOLD) |->
    (phy_oe && phy_ctl == plpt_pkg::CTL_IDLE)[*8] ##1
    (phy_oe && phy_ctl == plpt_pkg::CTL_IDLE)[*2] ##1 phy_ctl == plpt_pkg::CTL_TRANSMIT)
    else $error("no regrant after hold gap");
  a_lost_drops_req: assert property (link_bus_request_pin && ctl == plpt_pkg::CTL_RECEIVE |->
    ##[1:2] !link_bus_request_pin)
    else $error("request kept during receive");
  a_req_after_idle: assert property (live_q && $rose(link_bus_request_pin) |->
    $past(ctl, 1) == plpt_pkg::CTL_IDLE && $past(ctl, 2) == plpt_pkg::CTL_IDLE)
    else $error("request raised too soon");
endmodule

/* File: dv/plpt_tb_top.sv */
// Self-checking bench joining the phy end and the link end
module phy_link_packet_transfer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, arb_won = 0, node_is_root = 0, iso_mode = 0;
  logic cable_rx_active = 0, cable_rx_valid = 0, cable_rx_speed200 = 0;
  logic [3:0] cable_rx_data = 4'h0, tx_data = 4'h0;
  logic [2:0] power_class_pins = 3'h0, pwr_field;
  logic tx_valid = 0, tx_last = 0, tx_speed200 = 0, tx_ready, rx_valid, rx_speed200, rx_end;
  logic req_lost, cable_tx_valid, cable_tx_prefix, bus_pw, self_pw;
  logic [3:0] rx_data, cable_tx_data;
  logic [5:0] pwr_watts;
  logic [4:0] rxq[$];
  logic [3:0] txq[$];
  logic [5:0] watt_tab [8] = '{6'h00, 6'h0F, 6'h1E, 6'h2D, 6'h00, 6'h02, 6'h05, 6'h09};
  int err_count = 0, checked = 0, seed = 32'h9bad7c57, cycles = 0, pre_cnt = 0, lost_cnt = 0;
  int end_cnt = 0;
  plpt_if bus_if (.clk(clock));
  plpt_phy_end plpt_phy_end_inst (.clock(clock), .rst(rst), .bus(bus_if), .arb_won(arb_won),
    .node_is_root(node_is_root), .iso_mode(iso_mode), .cable_rx_active(cable_rx_active),
    .cable_rx_valid(cable_rx_valid), .cable_rx_data(cable_rx_data),
    .cable_rx_speed200(cable_rx_speed200), .power_class_pins(power_class_pins),
    .cable_tx_valid(cable_tx_valid), .cable_tx_data(cable_tx_data),
    .cable_tx_prefix(cable_tx_prefix), .pwr_field(pwr_field), .pwr_bus_powered(bus_pw),
    .pwr_self_powered(self_pw), .pwr_watts(pwr_watts));
  plpt_link_end plpt_link_end_inst (.clock(clock), .rst(rst), .bus(bus_if),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .tx_speed200(tx_speed200), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_speed200(rx_speed200), .rx_end(rx_end), .req_lost(req_lost));
  plpt_monitor plpt_monitor_inst (.clk(clock), .rst(rst), .phy_oe(bus_if.phy_oe),
    .phy_ctl(bus_if.phy_ctl), .phy_d(bus_if.phy_d), .link_oe(bus_if.link_oe),
    .link_ctl(bus_if.link_ctl), .link_d(bus_if.link_d),
    .link_bus_request_pin(bus_if.link_bus_request_pin),
    .ctl(bus_if.ctl), .d(bus_if.d));
  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp_word(input logic [5:0] act, input logic [5:0] exp);
    checked++;
    if (act !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t act=%0h exp=%0h", $time, act, exp);
    end
  endtask
  task automatic cmp_bit(input logic act, input logic exp);
    cmp_word({5'h00, act}, {5'h00, exp});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Queue a packet into the link FIFO; the far side may stall meanwhile
  task automatic push_pkt(input int n, input logic fast);
    logic [3:0] w;
    for (int i = 0; i < n; i++) begin
      w = 4'($random(seed));
      tx_valid <= 1'b1;
      tx_data <= w;
      tx_last <= (i == n - 1);
      tx_speed200 <= fast;
      txq.push_back(fast ? w : (w & plpt_pkg::MASK_100));
      @(posedge clock);
      while (!tx_ready) @(posedge clock);
    end
    tx_valid <= 1'b0;
  endtask
  // Cable delivers a packet; first word lands on the third edge
  task automatic rx_pkt(input int n, input logic fast);
    logic [3:0] w;
    cable_rx_active <= 1'b1;
    cable_rx_speed200 <= fast;
    repeat (2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      w = 4'($random(seed));
      cable_rx_valid <= 1'b1;
      cable_rx_data <= w;
      rxq.push_back({fast, fast ? w : (w & plpt_pkg::MASK_100)});
      @(posedge clock);
    end
    cable_rx_active <= 1'b0;
    cable_rx_valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic drain(input string name);
    while (txq.size() + rxq.size() > 0) @(posedge clock);
    repeat (30) @(posedge clock);
    $display("test %0s done", name);
  endtask
  // ----------------------------------------------------------------
  // Output watcher and timeout
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    pre_cnt += cable_tx_prefix;
    lost_cnt += req_lost;
    end_cnt += rx_end;
    if (rx_valid) begin
      cmp_word({1'b0, rx_speed200, rx_data}, {1'b0, rxq.pop_front()});
    end
    if (cable_tx_valid) begin
      cmp_word({2'h0, cable_tx_data}, {2'h0, txq.pop_front()});
    end
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    forever #2 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      power_class_pins <= 3'(p);
      repeat (6) @(posedge clock);
      cmp_word({3'h0, pwr_field}, {3'h0, 3'(p)});
      cmp_word(pwr_watts, watt_tab[{p[0], p[1], p[2]}]);
      cmp_bit(bus_pw, p[0]);
      cmp_bit(self_pw, !p[0] && p[2:1] != 2'h0);
    end
    $display("test power done");
    rx_pkt(5, 1'b1);
    rx_pkt(4, 1'b0);
    drain("receive");
    cmp_word(6'(end_cnt), 6'h02);
    arb_won <= 1'b1;
    push_pkt(3, 1'b1);
    push_pkt(3, 1'b1);
    drain("transmit and concatenation");
    arb_won <= 1'b0;
    push_pkt(8, 1'b0);
    @(posedge clock);
    cmp_bit(tx_ready, 1'b0);
    arb_won <= 1'b1;
    drain("fifo fill");
    cmp_bit(tx_ready, 1'b1);
    arb_won <= 1'b0;
    push_pkt(2, 1'b1);
    while (!bus_if.link_bus_request_pin) @(posedge clock);
    rx_pkt(2, 1'b0);
    cmp_bit(lost_cnt > 0, 1'b1);
    arb_won <= 1'b1;
    drain("request lost");
    arb_won <= 1'b0;
    node_is_root <= 1'b1;
    iso_mode <= 1'b1;
    pre_cnt = 0;
    push_pkt(3, 1'b1);
    drain("root isochronous");
    cmp_bit(pre_cnt >= int'(plpt_pkg::PREFIX_EXT_CYC), 1'b1);
    report_and_stop();
  end
endmodule
